// >>> rtl/ertif_pkg.sv
package ertif_pkg;

    // Register byte offsets on the APB window.
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_TIMER = 8'h04;
    localparam logic [7:0] ADDR_THRESH = 8'h08;
    localparam logic [7:0] ADDR_PENDING = 8'h0C;
    localparam logic [7:0] ADDR_STATUS = 8'h10;
    localparam logic [7:0] ADDR_MASK = 8'h14;

    // Control field: one bit per base address window pair (0/1, 2/3, 4/5) set when 64-bit.
    localparam int CTRL_PAIR64_LSB = 0;
    localparam int CTRL_PAIR64_W = 3;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;

    // Update timer reload in clock cycles, and per-type thresholds (one byte each).
    localparam int TIMER_W = 16;
    localparam logic [15:0] TIMER_RST = 16'h0800;
    localparam logic [31:0] THRESH_RST = 32'h0808_0808;

    // Credit type indices, used for buffer-full bits, thresholds and pending bytes.
    localparam int TYPE_PH = 0;
    localparam int TYPE_PD = 1;
    localparam int TYPE_NPH = 2;
    localparam int TYPE_NPD = 3;
    localparam int NUM_TYPES = 4;
    localparam int CRED_W = 8;

    // Interrupt status bit positions.
    localparam int EV_UR_NP = 0;
    localparam int EV_UR_P = 1;
    localparam int EV_CRC = 2;
    localparam int EV_MALF = 3;
    localparam int EV_BUF_FULL = 4;
    localparam int NUM_EV = 5;
    localparam logic [4:0] MASK_RST = 5'h00;

    // Address-match vector width: expansion ROM on top, six windows below.
    localparam int MATCH_W = 7;

    // Packet tracker states.
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_BODY = 2'b10
    } ertif_state_t;

endpackage

// >>> rtl/ertif_rx_top.sv
module ertif_rx_top
    import ertif_pkg::*;
#(
    parameter int DATA_W = 64,
    parameter bit ECRC_EN = 1'b1
) (
    // Clock and reset.
    input wire logic ref_clk_i,
    input wire logic srst_i,
    // APB slave.
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Beats from the transaction layer, data already in wire byte order.
    input wire logic rx_beat_valid_i,
    input wire logic [DATA_W-1:0] rx_beat_data_i,
    input wire logic rx_beat_first_i,
    input wire logic rx_beat_last_i,
    input wire logic rx_beat_half_i,
    input wire logic rx_crc_bad_i,
    input wire logic rx_locked_read_i,
    input wire logic rx_format_bad_i,
    input wire logic [MATCH_W-1:0] rx_window_match_i,
    // Received packet stream to the user.
    output logic receive_packet_valid_o,
    output logic [DATA_W-1:0] receive_packet_data_o,
    output logic receive_packet_first_o,
    output logic receive_packet_last_o,
    output logic receive_upper_half_only_o,
    output logic receive_crc_fail_flag_o,
    output logic receive_unsupported_flag_o,
    output logic receive_malformed_flag_o,
    output logic [MATCH_W-1:0] receive_addr_match_o,
    // Flow-control reports from the user.
    input wire logic user_unsupported_nonposted_i,
    input wire logic user_unsupported_posted_i,
    input wire logic [NUM_TYPES-1:0] user_buffer_full_per_type_i,
    input wire logic [1:0] header_credit_consumed_i,
    input wire logic [1:0] data_credit_consumed_strobe_i,
    input wire logic [15:0] data_credit_consumed_count_i,
    // Update request to the link layer and interrupt.
    output logic fc_update_o,
    output logic [NUM_TYPES-1:0] fc_update_type_o,
    output logic irq_o
);

    // Folds the upper window of each 64-bit pair onto the lower one.
    function automatic logic [MATCH_W-1:0] fold_match(
        input logic [MATCH_W-1:0] raw,
        input logic [CTRL_PAIR64_W-1:0] pair64
    );
        logic [MATCH_W-1:0] m;
        m = raw;
        for (int p = 0; p < CTRL_PAIR64_W; p++) begin
            if (pair64[p]) begin
                m[2*p] = raw[2*p] | raw[2*p+1];
                m[2*p+1] = 1'b0;
            end
        end
        return m;
    endfunction

    // Saturating credit add, so a stalled update never wraps the count.
    function automatic logic [CRED_W-1:0] sat_add(
        input logic [CRED_W-1:0] a,
        input logic [CRED_W-1:0] b
    );
        logic [CRED_W:0] s;
        s = {1'b0, a} + {1'b0, b};
        return s[CRED_W] ? {CRED_W{1'b1}} : s[CRED_W-1:0];
    endfunction

    // A type has reached its update threshold. A zero threshold never hits,
    // which lets software leave a type to the timer and buffer-full causes.
    function automatic logic thresh_hit(
        input logic [CRED_W-1:0] pend,
        input logic [CRED_W-1:0] thr
    );
        return (thr != '0) && (pend >= thr);
    endfunction

    ertif_state_t state_q;
    logic [31:0] ctrl_q;
    logic [TIMER_W-1:0] timer_rld_q;
    logic [TIMER_W-1:0] timer_cnt_q;
    logic [31:0] thresh_q;
    logic [CRED_W-1:0] pend_q [NUM_TYPES];
    logic [NUM_EV-1:0] status_q;
    logic [NUM_EV-1:0] mask_q;
    logic [NUM_EV-1:0] ev_set;
    logic [CRED_W-1:0] cred_add [NUM_TYPES];
    logic [NUM_TYPES-1:0] fire;
    logic timer_expire;
    logic wr_acc;
    logic beat_first;
    logic beat_mid;

    // The access phase is always one cycle: pready is raised at the setup edge.
    assign wr_acc = psel_i & penable_i & pready_o & pwrite_i;
    assign beat_first = rx_beat_valid_i & rx_beat_first_i;
    assign beat_mid = rx_beat_valid_i & ~rx_beat_first_i & (state_q == ST_BODY);

    // APB answer: read data and error are captured in setup, shown in access.
    // Decoding in the setup cycle keeps the read mux off the access cycle, and
    // because the reply is zero outside it a stale word never leaks onto the bus.
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o <= 32'h0000_0000;
        end else begin
            pready_o <= psel_i & ~penable_i;
            pslverr_o <= 1'b0;
            prdata_o <= 32'h0000_0000;
            if (psel_i & ~penable_i) begin
                case (paddr_i)
                    ADDR_CTRL: prdata_o <= ctrl_q;
                    ADDR_TIMER: prdata_o <= {{(32-TIMER_W){1'b0}}, timer_rld_q};
                    ADDR_THRESH: prdata_o <= thresh_q;
                    ADDR_PENDING: prdata_o <= {pend_q[3], pend_q[2], pend_q[1], pend_q[0]};
                    ADDR_STATUS: prdata_o <= {{(32-NUM_EV){1'b0}}, status_q};
                    ADDR_MASK: prdata_o <= {{(32-NUM_EV){1'b0}}, mask_q};
                    default: pslverr_o <= 1'b1; // Unmapped: error, data zero.
                endcase
            end
        end
    end

    // Writable configuration registers.
    // A new timer reload is used from the next expiry on; the running count
    // is left alone, so a write never shortens the interval in progress.
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            ctrl_q <= CTRL_RST;
            timer_rld_q <= TIMER_RST;
            thresh_q <= THRESH_RST;
            mask_q <= MASK_RST;
        end else if (wr_acc) begin
            case (paddr_i)
                ADDR_CTRL: ctrl_q <= {{(32-CTRL_PAIR64_W){1'b0}}, pwdata_i[CTRL_PAIR64_W-1:0]};
                ADDR_TIMER: timer_rld_q <= pwdata_i[TIMER_W-1:0];
                ADDR_THRESH: thresh_q <= pwdata_i;
                ADDR_MASK: mask_q <= pwdata_i[NUM_EV-1:0];
                default: ;
            endcase
        end
    end

    // Packet tracker: a packet is open from its first beat until its last.
    // Stray beats outside an open packet are still delivered, but they may not
    // change the flags of the packet that already ended.
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            state_q <= ST_IDLE;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (beat_first && !rx_beat_last_i) begin
                        state_q <= ST_BODY;
                    end
                end
                ST_BODY: begin
                    if (rx_beat_valid_i && rx_beat_last_i) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // Beat delivery. Data is passed through registered; the transaction layer
    // already places byte N on the top octet for either bus width.
    // There is no back-pressure: the user must take a beat in the cycle that
    // its valid stands, since the next beat may follow right behind it.
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            receive_packet_valid_o <= 1'b0;
            receive_packet_data_o <= '0;
            receive_packet_first_o <= 1'b0;
            receive_packet_last_o <= 1'b0;
            receive_upper_half_only_o <= 1'b0;
        end else begin
            receive_packet_valid_o <= rx_beat_valid_i;
            receive_packet_first_o <= beat_first;
            receive_packet_last_o <= rx_beat_valid_i & rx_beat_last_i;
            if (rx_beat_valid_i) begin
                receive_packet_data_o <= rx_beat_data_i;
            end
            // The narrow bus has no upper half, so the flag stays low there.
            receive_upper_half_only_o <= (DATA_W == 64) & rx_beat_valid_i & rx_beat_half_i;
        end
    end

    // Per-packet flags: loaded on the first beat, accumulated over later beats,
    // then held until the next packet starts, so they span first to last.
    // Holding them past the end beat lets the user sample them late.
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            receive_crc_fail_flag_o <= 1'b0;
            receive_unsupported_flag_o <= 1'b0;
            receive_malformed_flag_o <= 1'b0;
        end else if (beat_first) begin
            receive_crc_fail_flag_o <= ECRC_EN & rx_crc_bad_i;
            receive_unsupported_flag_o <= rx_locked_read_i;
            receive_malformed_flag_o <= rx_format_bad_i;
        end else if (beat_mid) begin
            receive_crc_fail_flag_o <= receive_crc_fail_flag_o | (ECRC_EN & rx_crc_bad_i);
            receive_unsupported_flag_o <= receive_unsupported_flag_o | rx_locked_read_i;
            receive_malformed_flag_o <= receive_malformed_flag_o | rx_format_bad_i;
        end
    end

    // Address match changes only with the start flag and holds for the packet.
    // The pair fold uses the control bits of that same cycle, so changing
    // them mid-packet cannot alter the vector already shown.
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            receive_addr_match_o <= '0;
        end else if (beat_first) begin
            receive_addr_match_o <= fold_match(rx_window_match_i,
                ctrl_q[CTRL_PAIR64_LSB +: CTRL_PAIR64_W]);
        end
    end

    // Update timer: counts down and reloads; expiry forces an update of all types.
    // A reload of zero makes every cycle an expiry, which is legal but floods
    // the link layer with updates.
    assign timer_expire = (timer_cnt_q == '0);
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            timer_cnt_q <= TIMER_RST;
        end else if (timer_expire) begin
            timer_cnt_q <= timer_rld_q;
        end else begin
            timer_cnt_q <= timer_cnt_q - 1'b1;
        end
    end

    // Credits consumed this cycle, per type. Header types count one per high
    // cycle; data types take the count only while the strobe is high.
    always_comb begin
        cred_add[TYPE_PH] = {7'h00, header_credit_consumed_i[0]};
        cred_add[TYPE_NPH] = {7'h00, header_credit_consumed_i[1]};
        cred_add[TYPE_PD] = data_credit_consumed_strobe_i[0] ?
            data_credit_consumed_count_i[7:0] : 8'h00;
        cred_add[TYPE_NPD] = data_credit_consumed_strobe_i[1] ?
            data_credit_consumed_count_i[15:8] : 8'h00;
    end

    // A type fires on buffer full, on timer expiry, or when its pending count
    // reaches a nonzero threshold. A zero threshold disables that trigger.
    always_comb begin
        for (int t = 0; t < NUM_TYPES; t++) begin
            fire[t] = user_buffer_full_per_type_i[t] | timer_expire
                | thresh_hit(pend_q[t], thresh_q[t*CRED_W +: CRED_W]);
        end
    end

    // Pending credit counters. On an update the credits of that same cycle
    // start the new count, so nothing consumed at the update edge is lost.
    // Saturation at all ones can only undercount, never report phantom credit.
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            for (int t = 0; t < NUM_TYPES; t++) begin
                pend_q[t] <= '0;
            end
        end else begin
            for (int t = 0; t < NUM_TYPES; t++) begin
                if (fire[t]) begin
                    pend_q[t] <= cred_add[t];
                end else begin
                    pend_q[t] <= sat_add(pend_q[t], cred_add[t]);
                end
            end
        end
    end

    // Update request toward the link layer, one cycle per decision.
    // A cause that persists, such as a full buffer held high, repeats the
    // request every cycle; the link layer is expected to merge them.
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            fc_update_o <= 1'b0;
            fc_update_type_o <= '0;
        end else begin
            fc_update_o <= |fire;
            fc_update_type_o <= fire;
        end
    end

    // Interrupt events. Packet errors count once, at the last beat.
    // The user's unsupported reports are one event per high cycle.
    always_comb begin
        ev_set = '0;
        ev_set[EV_UR_NP] = user_unsupported_nonposted_i;
        ev_set[EV_UR_P] = user_unsupported_posted_i;
        ev_set[EV_CRC] = receive_packet_last_o & receive_crc_fail_flag_o;
        ev_set[EV_MALF] = receive_packet_last_o & receive_malformed_flag_o;
        ev_set[EV_BUF_FULL] = |user_buffer_full_per_type_i;
    end

    // Sticky status, write one to clear; a new event wins over the clear.
    // Letting the event win means software can never lose an event that
    // lands in the very cycle of its clear.
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            status_q <= '0;
        end else if (wr_acc && (paddr_i == ADDR_STATUS)) begin
            status_q <= (status_q & ~pwdata_i[NUM_EV-1:0]) | ev_set;
        end else begin
            status_q <= status_q | ev_set;
        end
    end

    // Level interrupt, registered so the output comes from a flop.
    // This costs one cycle of latency but keeps the pin free of glitches.
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(status_q & mask_q);
        end
    end

endmodule

// >>> sim/ertif_rx_monitor.sv
module ertif_rx_monitor
    import ertif_pkg::*;
#(
    parameter int DATA_W = 64
) (
    // Clock, reset and beats in.
    input wire logic ref_clk_i,
    input wire logic srst_i,
    input wire logic rx_beat_valid_i,
    input wire logic [DATA_W-1:0] rx_beat_data_i,
    input wire logic rx_beat_first_i,
    input wire logic rx_beat_last_i,
    input wire logic rx_beat_half_i,
    input wire logic rx_locked_read_i,
    input wire logic rx_format_bad_i,
    input wire logic [NUM_TYPES-1:0] user_buffer_full_per_type_i,
    // Stream and updates out.
    input wire logic receive_packet_valid_o,
    input wire logic [DATA_W-1:0] receive_packet_data_o,
    input wire logic receive_packet_first_o,
    input wire logic receive_packet_last_o,
    input wire logic receive_upper_half_only_o,
    input wire logic receive_unsupported_flag_o,
    input wire logic receive_malformed_flag_o,
    input wire logic [MATCH_W-1:0] receive_addr_match_o,
    input wire logic fc_update_o,
    input wire logic [NUM_TYPES-1:0] fc_update_type_o
);
    // One clock domain, so clock and reset are stated once.
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (srst_i);

    property p_first; rx_beat_valid_i && rx_beat_first_i |=> receive_packet_first_o; endproperty
    a_first: assert property (p_first) else $error("start flag missing");
    property p_last; rx_beat_valid_i |=> receive_packet_last_o == $past(rx_beat_last_i); endproperty
    a_last: assert property (p_last) else $error("end flag wrong");
    property p_data; rx_beat_valid_i |=> receive_packet_data_o == $past(rx_beat_data_i); endproperty
    a_data: assert property (p_data) else $error("beat data reordered");
    property p_half; rx_beat_valid_i |=> receive_upper_half_only_o == $past(rx_beat_half_i); endproperty
    a_half: assert property (p_half) else $error("half flag wrong");
    property p_ur; rx_beat_valid_i && rx_beat_first_i && rx_locked_read_i |=> receive_unsupported_flag_o; endproperty
    a_ur: assert property (p_ur) else $error("locked read not flagged");
    property p_malf; rx_beat_valid_i && rx_beat_first_i && rx_format_bad_i |=> receive_malformed_flag_o; endproperty
    a_malf: assert property (p_malf) else $error("malformed not flagged");
    property p_match; !receive_packet_first_o |-> $stable(receive_addr_match_o); endproperty
    a_match: assert property (p_match) else $error("match moved off start");
    property p_hold; receive_unsupported_flag_o && !(rx_beat_valid_i && rx_beat_first_i) |=> receive_unsupported_flag_o; endproperty
    a_hold: assert property (p_hold) else $error("flag dropped mid packet");
    property p_full; |user_buffer_full_per_type_i |=> ##[0:1] fc_update_o; endproperty
    a_full: assert property (p_full) else $error("no update on buffer full");
endmodule

bind ertif_rx_top ertif_rx_monitor #(.DATA_W(DATA_W)) ertif_rx_monitor_i (.*);

// >>> sim/ertif_user_model.sv
module ertif_user_model (
    // Clock, reset and packet end with its flag.
    input wire logic ref_clk_i,
    input wire logic srst_i,
    input wire logic last_i,
    input wire logic unsup_i,
    // Bench commands.
    input wire logic dc_go_i,
    input wire logic [7:0] dc_cnt_i,
    input wire logic ur_p_go_i,
    // Reports to the device.
    output logic ur_np_o,
    output logic ur_p_o,
    output logic [1:0] dc_strobe_o,
    output logic [15:0] dc_count_o
);
    logic go_q;

    // A flagged packet is answered with an unsupported completion once it has ended.
    always_ff @(posedge ref_clk_i) begin
        ur_np_o <= !srst_i && last_i && unsup_i;
        ur_p_o <= !srst_i && ur_p_go_i;
    end

    // Count leads the one-cycle strobe; it then toggles, so a late sample reads garbage.
    always_ff @(posedge ref_clk_i) begin
        go_q <= !srst_i && dc_go_i;
        dc_strobe_o <= {2{go_q && !srst_i}};
        if (srst_i) begin
            dc_count_o <= 16'h0000;
        end else if (dc_go_i) begin
            dc_count_o <= {dc_cnt_i, dc_cnt_i};
        end else if (!go_q) begin
            dc_count_o <= ~dc_count_o;
        end
    end
endmodule

// >>> sim/ertif_tb_top.sv
module ertif_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import ertif_pkg::*;

    // Design ports, named as the design names them.
    logic ref_clk_i, srst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, irq_o;
    logic [7:0] paddr_i;
    logic [31:0] pwdata_i, prdata_o;
    logic rx_beat_valid_i, rx_beat_first_i, rx_beat_last_i, rx_beat_half_i;
    logic rx_crc_bad_i, rx_locked_read_i, rx_format_bad_i;
    logic [63:0] rx_beat_data_i, receive_packet_data_o;
    logic [6:0] rx_window_match_i, receive_addr_match_o;
    logic receive_packet_valid_o, receive_packet_first_o, receive_packet_last_o;
    logic receive_upper_half_only_o, receive_crc_fail_flag_o;
    logic receive_unsupported_flag_o, receive_malformed_flag_o;
    logic user_unsupported_nonposted_i, user_unsupported_posted_i, fc_update_o;
    logic [3:0] user_buffer_full_per_type_i, fc_update_type_o;
    logic [1:0] header_credit_consumed_i, data_credit_consumed_strobe_i;
    logic [15:0] data_credit_consumed_count_i;
    logic dc_go, ur_p_go;
    logic [7:0] dc_cnt;
    int error_cnt, n_tests;

    ertif_rx_top #(.DATA_W(64), .ECRC_EN(1'b1)) ertif_rx_top_i (.*);

    ertif_user_model ertif_user_model_i (
        .ref_clk_i(ref_clk_i),
        .srst_i(srst_i),
        .last_i(receive_packet_last_o),
        .unsup_i(receive_unsupported_flag_o),
        .dc_go_i(dc_go),
        .dc_cnt_i(dc_cnt),
        .ur_p_go_i(ur_p_go),
        .ur_np_o(user_unsupported_nonposted_i),
        .ur_p_o(user_unsupported_posted_i),
        .dc_strobe_o(data_credit_consumed_strobe_i),
        .dc_count_o(data_credit_consumed_count_i)
    );

    // Free-running 40 MHz clock.
    initial begin
        ref_clk_i = 1'b0;
        forever #12.5 ref_clk_i = ~ref_clk_i;
    end

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // One APB transfer; a read compares its data, both compare the error response.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic e);
        int n;
        @(posedge ref_clk_i);
        {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} <= {2'b10, w, a, d};
        @(posedge ref_clk_i);
        penable_i <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk_i);
            n++;
        end while (pready_o !== 1'b1 && n < 20);
        if (n >= 20) begin
            error_cnt++;
            complete_run();
        end
        check(32'(pslverr_o), 32'(e));
        if (!w) check(prdata_o, d);
        {psel_i, penable_i} <= 2'b00;
    endtask

    // One beat; f is {crc, format, locked, half, last, first}.
    task automatic beat(input logic [63:0] d, input logic [5:0] f, input logic [6:0] m);
        rx_beat_valid_i <= 1'b1;
        rx_beat_data_i <= d;
        rx_window_match_i <= m;
        {rx_crc_bad_i, rx_format_bad_i, rx_locked_read_i, rx_beat_half_i,
            rx_beat_last_i, rx_beat_first_i} <= f;
        @(posedge ref_clk_i);
    endtask

    // Waits a bounded time for an update pulse and compares its types.
    // Sampled at the edge, so the pulse launched one edge earlier is seen.
    task automatic wait_fc(input logic [3:0] exp);
        int n;
        n = 0;
        do begin
            @(posedge ref_clk_i);
            n++;
        end while (fc_update_o !== 1'b1 && n < 2200);
        if (n >= 2200) begin
            error_cnt++;
            complete_run();
        end
        check(32'(fc_update_type_o), 32'(exp));
    endtask

    initial begin
        error_cnt = 0;
        n_tests = 0;
        srst_i = 1'b1;
        {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i, rx_beat_valid_i, rx_beat_data_i,
            rx_beat_first_i, rx_beat_last_i, rx_beat_half_i, rx_crc_bad_i, rx_locked_read_i,
            rx_format_bad_i, rx_window_match_i, user_buffer_full_per_type_i,
            header_credit_consumed_i, dc_go, dc_cnt, ur_p_go} = '0;
        repeat (16) @(posedge ref_clk_i);
        srst_i <= 1'b0;
        apb(1'b0, ADDR_CTRL, 32'h0000_0000, 1'b0);
        apb(1'b0, ADDR_TIMER, 32'h0000_0800, 1'b0);
        apb(1'b0, ADDR_THRESH, 32'h0808_0808, 1'b0);
        apb(1'b0, ADDR_MASK, 32'h0000_0000, 1'b0);
        apb(1'b1, 8'h18, 32'hFFFF_FFFF, 1'b1);
        apb(1'b0, 8'h18, 32'h0000_0000, 1'b1);
        $display("test registers done");
        apb(1'b1, ADDR_CTRL, 32'h0000_0001, 1'b0);
        @(posedge ref_clk_i);
        ur_p_go <= 1'b1;
        beat(64'h0102_0304_0506_0708, 6'b001001, 7'h02);
        ur_p_go <= 1'b0;
        beat(64'h1112_1314_1516_1718, 6'b100000, 7'h00);
        beat(64'hA1B2_C3D4_E5F6_0718, 6'b000110, 7'h00);
        rx_beat_valid_i <= 1'b0;
        #1;
        check(receive_packet_data_o[63:32], 32'hA1B2_C3D4);
        check(32'({receive_packet_first_o, receive_packet_last_o}), 32'h1);
        check(32'(receive_packet_valid_o), 32'h1);
        check(32'(receive_upper_half_only_o), 32'h1);
        check(32'({receive_crc_fail_flag_o, receive_unsupported_flag_o}), 32'h3);
        check(32'(receive_addr_match_o), 32'h01);
        repeat (2) @(posedge ref_clk_i);
        beat(64'h0, 6'b010011, 7'h40);
        rx_beat_valid_i <= 1'b0;
        #1;
        check(32'({receive_packet_first_o, receive_packet_last_o, receive_crc_fail_flag_o,
            receive_unsupported_flag_o, receive_malformed_flag_o}), 32'h19);
        check(32'(receive_addr_match_o), 32'h40);
        $display("test packets done");
        apb(1'b0, ADDR_STATUS, 32'h0000_000F, 1'b0);
        check(32'(irq_o), 32'h0);
        apb(1'b1, ADDR_MASK, 32'h0000_0008, 1'b0);
        repeat (2) @(posedge ref_clk_i);
        check(32'(irq_o), 32'h1);
        apb(1'b1, ADDR_STATUS, 32'h0000_0008, 1'b0);
        repeat (2) @(posedge ref_clk_i);
        check(32'(irq_o), 32'h0);
        apb(1'b0, ADDR_STATUS, 32'h0000_0007, 1'b0);
        $display("test interrupt done");
        @(posedge ref_clk_i);
        {dc_go, dc_cnt, header_credit_consumed_i} <= {1'b1, 8'h05, 2'b11};
        @(posedge ref_clk_i);
        dc_go <= 1'b0;
        repeat (2) @(posedge ref_clk_i);
        header_credit_consumed_i <= 2'b00;
        apb(1'b1, ADDR_PENDING, 32'h0000_0000, 1'b0);
        apb(1'b0, ADDR_PENDING, 32'h0503_0503, 1'b0);
        apb(1'b1, ADDR_THRESH, 32'h0000_0004, 1'b0);
        header_credit_consumed_i <= 2'b01;
        @(posedge ref_clk_i);
        header_credit_consumed_i <= 2'b00;
        wait_fc(4'h1);
        for (int t = 0; t < 4; t++) begin
            @(posedge ref_clk_i);
            user_buffer_full_per_type_i <= 4'(1 << t);
            @(posedge ref_clk_i);
            user_buffer_full_per_type_i <= 4'h0;
            wait_fc(4'(1 << t));
        end
        wait_fc(4'hF);
        $display("test credits done");
        complete_run();
    end
endmodule
